// file: logic/bts_defines.svh
// constants of the bus transfer scheme: timing, sizes and reset values
`ifndef BTS_DEFINES_SVH
`define BTS_DEFINES_SVH

// clock and delay time base
`define BTS_CLK_PERIOD_NS   20
`define BTS_TICK_PERIOD_NS  1000000
`define BTS_TICK_CYCLES     (`BTS_TICK_PERIOD_NS / `BTS_CLK_PERIOD_NS)

// sizes
`define BTS_NUM_INC         2
`define BTS_DELAY_W         16
`define BTS_SYNC_STAGES     2

// reset values
`define BTS_NOT_READY_RST   1'b1
`define BTS_OPEN_IND_RST    1'b1
`define BTS_LINE_DEAD_RST   1'b1
`define BTS_OFF             1'b0

`endif

// file: logic/bts_pkg.sv
// types of the bus transfer scheme: pin groups, contact groups, tie states
package bts_pkg;

	// incomer logic inputs and element flags
	typedef struct packed {
		logic racked;      // racked-in input 5
		logic closeCmd;    // close command input 2
		logic openCmd;     // open command input 3
		logic inhibit;     // transfer inhibit input 11
		logic lockout;     // transformer lockout input 12
		logic srcTrip;     // source trip input 13
		logic uvInst;      // instantaneous undervoltage element picked up
		logic uvTimed;     // timed undervoltage element timed out
		logic lineLive;    // line voltage at nominal
		logic brkClosed;   // breaker auxiliary: closed
	} bts_inc_in_type;

	// incomer output contacts and breaker commands
	typedef struct packed {
		logic openInd;     // contact 1
		logic otherUv;     // contact 3
		logic lineDead;    // contact 4
		logic inSvcA;      // contact 5
		logic xferReq;     // contact 6
		logic inSvcB;      // contact 7
		logic tripOut;
		logic closeOut;
		logic notReady;
	} bts_inc_out_type;

	// bus-tie logic inputs
	typedef struct packed {
		logic racked;
		logic closeCmd;
		logic openCmd;
		logic syncOk;      // synchrocheck permits close
		logic brkClosed;
	} bts_tie_in_type;

	// bus-tie output contacts and breaker commands
	typedef struct packed {
		logic rackedA;     // contact 4
		logic closedA;     // contact 5
		logic rackedB;     // contact 6
		logic closedB;     // contact 7
		logic tripOut;
		logic closeOut;
	} bts_tie_out_type;

	typedef enum logic [4:0] {
		TIE_IDLE  = 5'b00001,
		TIE_PEND  = 5'b00010,
		TIE_CLOSE = 5'b00100,
		TIE_SHUT  = 5'b01000,
		TIE_TRIP  = 5'b10000
	} bts_tie_state_type;

endpackage

// file: logic/bts_sync.sv
// two-flop synchroniser with rising-edge detect for a vector of pins
`timescale 1ns/100ps
`default_nettype none

module bts_sync #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// pins
	input  wire logic [W-1:0] din,
	// synchronised levels and rising edges
	output logic      [W-1:0] dout,
	output logic      [W-1:0] rise
);

	logic [W-1:0] meta_r;
	logic [W-1:0] stab_r;
	logic [W-1:0] last_r;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			meta_r <= '0;
			stab_r <= '0;
			last_r <= '0;
		end
		else
		begin
			meta_r <= din;
			stab_r <= meta_r;
			last_r <= stab_r;
		end
	end

	// edge seen only on the settled stage
	assign dout = stab_r;
	assign rise = stab_r & ~last_r;

endmodule

`default_nettype wire

// file: logic/bts_scheme.sv
// two incomers and one bus tie: automatic bus transfer logic
`timescale 1ns/100ps
`default_nettype none
`include "bts_defines.svh"

// Operation
// - idle incomer: contacts 1,4 on, not ready
// - idle bus tie: contacts 4 to 7 off
// - tie contacts 4,6 follow tie racked input
// - incomer never closes onto dead line
// - pending close completes when line live
// - tie unracked makes both incomers not ready
// - incomer unracked drops 5,7, both not ready
// - open pulse trips incomer, drops 5,7
// - close pulse with voltage closes incomer
// - tie close pulse closes tie, not ready
// - tie open pulse trips tie, ready again
// - inhibit drops 5,7, both not ready
// - undervoltage pickup: contact 4, other not ready
// - other clears not ready after set delay
// - timed undervoltage trips the incomer breaker
// - lockout trips incomer, contact 6 requests tie
// - contact 6 drops once own breaker open
// - tie closes only when synchrocheck permits
// - source trip acts like lockout
// - double loss: optional trip block, tie holds
module bts_scheme
	import bts_pkg::*;
#(
	parameter int TICK_CYCLES = `BTS_TICK_CYCLES,
	parameter int DELAY_W     = `BTS_DELAY_W
) (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	// settings
	input  wire logic                       blockDoubleLoss,
	input  wire logic [DELAY_W-1:0]         xferDelayMs,
	// incomer pins
	input  wire bts_inc_in_type [1:0]       incPins,
	// bus-tie pins
	input  wire bts_tie_in_type             tiePins,
	// incomer contacts and commands
	output var  bts_inc_out_type [1:0]      incOut,
	// bus-tie contacts and commands
	output var  bts_tie_out_type            tieOut,
	// tie state for observation
	output var  logic                       tiePending
);

	localparam int INC_W  = $bits(bts_inc_in_type);
	localparam int TIE_W  = $bits(bts_tie_in_type);
	localparam int SYNC_W = `BTS_NUM_INC * INC_W + TIE_W;
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	// incomer in service: racked, closed and not inhibited
	function automatic logic incReady(input bts_inc_in_type p);
		incReady = p.racked & p.brkClosed & ~p.inhibit;
	endfunction

	// a trip that also asks the bus tie to take the load
	function automatic logic xferCause(input bts_inc_in_type p,
		input logic uvTrip);
		xferCause = p.lockout | p.srcTrip | uvTrip;
	endfunction

	// all pins pass the synchroniser before any logic
	bts_inc_in_type [1:0] inc;
	bts_inc_in_type [1:0] incRise;
	bts_tie_in_type       tie;
	bts_tie_in_type       tieRise;
	logic [SYNC_W-1:0]    syncLvl;
	logic [SYNC_W-1:0]    syncRise;

	bts_sync #(
		.W (SYNC_W)
	) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.din     ({tiePins, incPins}),
		.dout    (syncLvl),
		.rise    (syncRise)
	);

	assign {tie, inc}         = syncLvl;
	assign {tieRise, incRise} = syncRise;

	// millisecond tick for the transfer delay
	logic [TICK_W-1:0] tickCnt_r;
	logic              tick_r;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tickCnt_r <= '0;
			tick_r    <= `BTS_OFF;
		end
		else if (tickCnt_r >= TICK_LAST)
		begin
			tickCnt_r <= '0;
			tick_r    <= 1'b1;
		end
		else
		begin
			tickCnt_r <= tickCnt_r + TICK_W'(1);
			tick_r    <= `BTS_OFF;
		end
	end

	// shared conditions
	logic       bothLost;
	logic       tiePermit;
	logic [1:0] ready;
	logic [1:0] uvTrip;
	logic [1:0] xferReq;
	logic [1:0] uvHold;

	assign bothLost = ~inc[0].lineLive & ~inc[1].lineLive;
	// dead bus or one dead line is judged by synchrocheck; both lines dead blocks the tie
	assign tiePermit = tie.racked & tie.syncOk & ~bothLost;

	// bus-tie breaker control
	bts_tie_state_type tieState_r;
	bts_tie_state_type tieState_nxt;
	logic              tieReq;

	// a request from either incomer or an operator close pulse
	assign tieReq = tieRise.closeCmd | (|xferReq);

	always_comb
	begin
		tieState_nxt = tieState_r;
		case (tieState_r)
			TIE_IDLE:
			begin
				if (tie.brkClosed)
					tieState_nxt = TIE_SHUT;
				else if (tieReq)
					tieState_nxt = TIE_PEND;
			end
			TIE_PEND:
			begin
				// request held after contact 6 drops
				if (tieRise.openCmd)
					tieState_nxt = TIE_IDLE;
				else if (tie.brkClosed)
					tieState_nxt = TIE_SHUT;
				else if (tiePermit)
					tieState_nxt = TIE_CLOSE;
			end
			TIE_CLOSE:
			begin
				if (tieRise.openCmd)
					tieState_nxt = TIE_IDLE;
				else if (tie.brkClosed)
					tieState_nxt = TIE_SHUT;
				else if (!tiePermit)
					tieState_nxt = TIE_PEND;
			end
			TIE_SHUT:
			begin
				if (tieRise.openCmd)
					tieState_nxt = TIE_TRIP;
				else if (!tie.brkClosed)
					tieState_nxt = TIE_IDLE;
			end
			TIE_TRIP:
			begin
				if (!tie.brkClosed)
					tieState_nxt = TIE_IDLE;
			end
			default:
				tieState_nxt = TIE_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			tieState_r <= TIE_IDLE;
		else
			tieState_r <= tieState_nxt;
	end

	// bus-tie contacts and commands
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tieOut     <= '0;
			tiePending <= `BTS_OFF;
		end
		else
		begin
			tieOut.rackedA  <= tie.racked;
			tieOut.rackedB  <= tie.racked;
			tieOut.closedA  <= tie.brkClosed;
			tieOut.closedB  <= tie.brkClosed;
			tieOut.closeOut <= (tieState_nxt == TIE_CLOSE);
			tieOut.tripOut  <= (tieState_nxt == TIE_TRIP);
			tiePending      <= (tieState_nxt == TIE_PEND);
		end
	end

	// per-incomer logic
	genvar g;
	generate
		for (g = 0; g < `BTS_NUM_INC; g++)
		begin : g_inc
			localparam int OTH = `BTS_NUM_INC - 1 - g;

			logic               closePend_r;
			logic               openLatch_r;
			logic               tripDemand;
			logic [DELAY_W-1:0] holdCnt_r;
			logic               holdRun_r;

			// with blocking on, a double loss does not trip
			assign uvTrip[g] = inc[g].uvTimed
				& ~(blockDoubleLoss & bothLost);
			assign ready[g] = incReady(inc[g]);

			// contact 6 lives only while own breaker closed
			assign xferReq[g] = inc[g].brkClosed
				& xferCause(inc[g], uvTrip[g]);

			assign tripDemand = openLatch_r | incRise[g].openCmd
				| xferCause(inc[g], uvTrip[g]);

			// open pulse is latched until breaker opens
			always_ff @(posedge clk)
			begin
				if (sys_rst)
					openLatch_r <= `BTS_OFF;
				else if (incRise[g].openCmd)
					openLatch_r <= inc[g].brkClosed;
				else if (!inc[g].brkClosed)
					openLatch_r <= `BTS_OFF;
			end

			// close pulse waits for a live line
			always_ff @(posedge clk)
			begin
				if (sys_rst)
					closePend_r <= `BTS_OFF;
				else if (incRise[g].closeCmd)
					closePend_r <= ~inc[g].brkClosed;
				else if (inc[g].brkClosed || tripDemand)
					closePend_r <= `BTS_OFF;
			end

			// other-source undervoltage hold and delay
			always_ff @(posedge clk)
			begin
				if (sys_rst)
				begin
					holdRun_r <= `BTS_OFF;
					holdCnt_r <= '0;
				end
				else if (inc[OTH].uvInst)
				begin
					holdRun_r <= 1'b1;
					holdCnt_r <= '0;
				end
				else if (holdRun_r && tick_r)
				begin
					if (holdCnt_r >= xferDelayMs)
						holdRun_r <= `BTS_OFF;
					else
						holdCnt_r <= holdCnt_r + DELAY_W'(1);
				end
			end

			assign uvHold[g] = holdRun_r | inc[OTH].uvInst;

			// contacts and commands
			always_ff @(posedge clk)
			begin
				if (sys_rst)
				begin
					incOut[g]          <= '0;
					incOut[g].openInd  <= `BTS_OPEN_IND_RST;
					incOut[g].lineDead <= `BTS_LINE_DEAD_RST;
					incOut[g].notReady <= `BTS_NOT_READY_RST;
				end
				else
				begin
					incOut[g].openInd  <= ~inc[g].brkClosed;
					incOut[g].otherUv  <= inc[OTH].uvInst;
					incOut[g].lineDead <= ~inc[g].lineLive
						| inc[g].uvInst;
					incOut[g].inSvcA   <= ready[g];
					incOut[g].inSvcB   <= ready[g];
					incOut[g].xferReq  <= xferReq[g];
					incOut[g].tripOut  <= tripDemand
						& inc[g].brkClosed;
					incOut[g].closeOut <= closePend_r & ~tripDemand
						& inc[g].racked & inc[g].lineLive
						& ~inc[g].brkClosed;
					// ready needs both incomers, tie racked and open
					incOut[g].notReady <= ~ready[0] | ~ready[1]
						| ~tie.racked | tie.brkClosed
						| uvHold[g];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// file: bench/bts_breakers.sv
// breaker mechanisms answering trip and close commands
`timescale 1ns/100ps
`default_nettype none
module bts_breakers
	import bts_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	// commands
	input  wire bts_inc_out_type [1:0] incOut,
	input  wire bts_tie_out_type       tieOut,
	// auxiliary contacts, high when closed
	output var  logic [2:0]            brk
);
	logic [2:0] cls;
	logic [2:0] trp;
	logic [3:0] cAge [3];
	logic [3:0] tAge [3];
	assign cls = {tieOut.closeOut, incOut[1].closeOut, incOut[0].closeOut};
	assign trp = {tieOut.tripOut, incOut[1].tripOut, incOut[0].tripOut};
	// coil needs a command held four cycles; trip wins
	always_ff @(posedge clk)
		for (int i = 0; i < 3; i++)
		begin
			cAge[i] <= sys_rst ? 4'h0 : {cAge[i][2:0], cls[i]};
			tAge[i] <= sys_rst ? 4'h0 : {tAge[i][2:0], trp[i]};
			if (sys_rst || &tAge[i])
				brk[i] <= 1'b0;
			else if (&cAge[i])
				brk[i] <= 1'b1;
		end
endmodule
`default_nettype wire

// file: bench/bts_scheme_properties.sv
// port checks of the bus transfer scheme
`timescale 1ns/100ps
`default_nettype none
module bts_scheme_check
	import bts_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	// pins
	input  wire bts_inc_in_type [1:0]  incPins,
	input  wire bts_tie_in_type        tiePins,
	// contacts
	input  wire bts_inc_out_type [1:0] incOut,
	input  wire bts_tie_out_type       tieOut
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	AST_TIE_RACK_ON: assert property (
		$rose(tiePins.racked) |-> ##[2:4] (tieOut.rackedA && tieOut.rackedB))
		else $error("tie racked contacts late");
	AST_TIE_RACK_OFF: assert property (
		$fell(tiePins.racked) |-> ##[2:5] (!tieOut.rackedA
		&& incOut[0].notReady && incOut[1].notReady))
		else $error("tie unracked not shown");
	AST_TIE_CLOSED: assert property (
		$rose(tiePins.brkClosed) |-> ##[2:5] (tieOut.closedA && tieOut.closedB))
		else $error("tie closed contacts late");
	AST_INC_PAIR: assert property (
		incOut[0].inSvcA == incOut[0].inSvcB
		&& incOut[1].inSvcA == incOut[1].inSvcB)
		else $error("contacts 5 and 7 differ");
	AST_INC_TRIPPED: assert property (
		$fell(incPins[0].brkClosed) |-> ##[2:5]
		(incOut[0].openInd && !incOut[0].inSvcA))
		else $error("trip not indicated");
	AST_NO_DEAD_CLOSE: assert property (
		$rose(incOut[0].closeOut) |-> incPins[0].lineLive && incPins[0].racked)
		else $error("close onto dead line");
	AST_LOCK_REQ: assert property (
		$rose(incPins[1].lockout) && incPins[1].brkClosed |-> ##[2:5]
		(incOut[1].tripOut && incOut[1].xferReq))
		else $error("lockout trip missing");
	AST_REQ_DROP: assert property (
		incOut[1].xferReq && !incPins[1].brkClosed |-> ##[0:4] !incOut[1].xferReq)
		else $error("request outlives breaker");
	AST_TIE_PERMIT: assert property (
		$rose(tieOut.closeOut) |-> tiePins.syncOk)
		else $error("tie closed without permit");
endmodule
bind bts_scheme bts_scheme_check u_chk (.clk(clk), .sys_rst(sys_rst),
	.incPins(incPins), .tiePins(tiePins), .incOut(incOut), .tieOut(tieOut));
`default_nettype wire

// file: bench/bts_scheme_tb.sv
// testbench of the bus transfer scheme
`timescale 1ns/100ps
`default_nettype none
module bts_scheme_tb
	import bts_pkg::*;
;
	logic                  clk;
	logic                  sys_rst;
	logic [2:0]            brk;
	logic                  tiePending;
	logic                  blockDoubleLoss;
	int                    miscompares;
	int                    samples_checked;
	bts_inc_in_type [1:0]  inc;
	bts_inc_in_type [1:0]  incPins;
	bts_tie_in_type        tie;
	bts_tie_in_type        tiePins;
	bts_inc_out_type [1:0] incOut;
	bts_tie_out_type       tieOut;
	// breaker feedback comes from the model only
	always_comb
	begin
		incPins = inc;
		incPins[0].brkClosed = brk[0];
		incPins[1].brkClosed = brk[1];
		tiePins = tie;
		tiePins.brkClosed = brk[2];
	end
	bts_scheme #(.TICK_CYCLES(10), .DELAY_W(16)) dut (.clk(clk),
		.sys_rst(sys_rst), .blockDoubleLoss(blockDoubleLoss),
		.xferDelayMs(16'h0003),
		.incPins(incPins), .tiePins(tiePins), .incOut(incOut),
		.tieOut(tieOut), .tiePending(tiePending));
	bts_breakers brks (.clk(clk), .sys_rst(sys_rst), .incOut(incOut),
		.tieOut(tieOut), .brk(brk));
	task step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task chk(input logic [3:0] g, input logic [3:0] e);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task look(input int i, input logic [3:0] e);
		step(10);
		chk({incOut[i].inSvcA, incOut[i].inSvcB, incOut[0].notReady,
			incOut[1].notReady}, e);
	endtask
	// i = 2 is the tie; cl picks close over open
	task pulse(input int i, input bit cl);
		if (i == 2)
			{tie.closeCmd, tie.openCmd} = {cl, !cl};
		else
			{inc[i].closeCmd, inc[i].openCmd} = {cl, !cl};
		step(2);
		{tie.closeCmd, tie.openCmd, inc[0].closeCmd} = 3'h0;
		{inc[0].openCmd, inc[1].closeCmd, inc[1].openCmd} = 3'h0;
		step(16);
	endtask
	task final_report;
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		#(20 * 5000);
		miscompares++;
		final_report;
	end
	initial
	begin
		inc = '0;
		tie = '0;
		blockDoubleLoss = 0;
		sys_rst = 1;
		miscompares = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk);
		#2 sys_rst = 0;
		step(6);
		chk({incOut[0].lineDead, incOut[0].notReady, incOut[0].openInd,
			incOut[0].inSvcA}, 4'he);
		chk({incOut[1].lineDead, incOut[1].openInd, incOut[1].inSvcB}, 4'h6);
		chk(tieOut[5:2], 4'h0);
		tie.racked = 1;
		step(8);
		chk(tieOut[5:2], 4'ha);
		for (int i = 0; i < 2; i++)
		begin
			inc[i].racked = 1;
			pulse(i, 1);
			chk({brk[i], incOut[i].closeOut}, 4'h0);
			inc[i].lineLive = 1;
			step(20);
			chk({brk[i], incOut[i].lineDead, incOut[i].inSvcA}, 4'h5);
		end
		tie.racked = 0;
		look(0, 4'hf);
		tie.racked = 1;
		look(0, 4'hc);
		for (int i = 0; i < 2; i++)
		begin
			inc[i].racked = 0;
			look(i, 4'h3);
			inc[i].racked = 1;
			look(i, 4'hc);
			inc[i].inhibit = 1;
			look(i, 4'h3);
			inc[i].inhibit = 0;
			look(i, 4'hc);
			pulse(i, 0);
			look(i, 4'h3);
			pulse(i, 1);
			look(i, 4'hc);
		end
		tie.syncOk = 1;
		pulse(2, 1);
		look(0, 4'hf);
		pulse(2, 0);
		look(0, 4'hc);
		inc[0].uvInst = 1;
		step(8);
		chk({incOut[0].lineDead, incOut[1].otherUv, incOut[1].notReady}, 4'h7);
		inc[0].uvInst = 0;
		step(8);
		chk({incOut[0].lineDead, incOut[1].notReady}, 4'h1);
		step(50);
		chk(incOut[1].notReady, 4'h0);
		{inc[0].uvInst, inc[0].lineLive, inc[0].uvTimed} = 3'b101;
		step(40);
		chk({brk[0], brk[2]}, 4'h1);
		{inc[0].uvInst, inc[0].lineLive, inc[0].uvTimed} = 3'b010;
		pulse(2, 0);
		pulse(0, 1);
		tie.syncOk = 0;
		inc[1].lockout = 1;
		step(30);
		chk({brk[1], incOut[1].xferReq, tiePending, brk[2]}, 4'h2);
		tie.syncOk = 1;
		step(20);
		chk({tiePending, brk[2]}, 4'h1);
		inc[1].lockout = 0;
		pulse(2, 0);
		pulse(1, 1);
		step(20);
		chk({brk[1], brk[2]}, 4'h2);
		tie.syncOk = 0;
		inc[1].srcTrip = 1;
		step(30);
		chk({brk[1], incOut[1].xferReq, tiePending, brk[2]}, 4'h2);
		pulse(2, 0);
		chk(tiePending, 4'h0);
		inc[1].srcTrip = 0;
		tie.syncOk = 1;
		pulse(1, 1);
		step(20);
		blockDoubleLoss = 1;
		{inc[0].lineLive, inc[1].lineLive} = 2'b00;
		{inc[0].uvTimed, inc[1].uvTimed} = 2'b11;
		step(30);
		chk({brk[0], brk[1], brk[2]}, 4'h6);
		blockDoubleLoss = 0;
		step(30);
		chk({brk[0], brk[1], brk[2], tiePending}, 4'h1);
		final_report;
	end
endmodule
`default_nettype wire
